// ===== rtl/pcs_core.sv
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pcs_regs.svh"

module pcs_core #(
	parameter int STACK_DEPTH = `PCS_STACK_DEPTH
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output wire logic                pready,
	output wire logic                pslverr,
	input  wire logic                fetch_strobe,
	input  wire logic                op_jump,
	input  wire logic                op_call,
	input  wire logic                op_return,
	input  wire logic                int_branch,
	input  wire pcs_pkg::pcs_target_t op_target,
	output pcs_pkg::pcs_addr_t       fetch_addr
);

	pcs_stk_if stk ();

	pcs_stack #(
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.clk_sys (clk_sys),
		.rst     (rst),
		.stk     (stk)
	);

	pcs_pkg::pcs_latch_t latch;
	pcs_pkg::pcs_addr_t  next_fetch_addr;
	logic [31:0]         next_prdata;

	// APB decode
	wire apb_setup  = psel & ~penable;
	wire apb_access = psel & penable;
	wire hit_low    = (paddr == `PCS_ADDR_LOW_BYTE);
	wire hit_latch  = (paddr == `PCS_ADDR_LATCH);
	// Only the low byte and the latch are mapped; stack and pointer never are
	wire addr_ok    = hit_low | hit_latch;
	wire low_wr     = apb_access & pwrite & hit_low;
	wire latch_wr   = apb_access & pwrite & hit_latch;

	// Zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = apb_access & ~addr_ok;

	// Read data: upper bits 12:8 are deliberately absent from this mux
	assign next_prdata = hit_low   ? {`PCS_PAD_LOW_BYTE, fetch_addr[`PCS_PC_LOW]} :
	                     hit_latch ? {`PCS_PAD_LATCH, latch} :
	                     `PCS_RDATA_RESET;

	// Redirect priority; the decoder is expected to raise one at a time
	wire pcs_pkg::pcs_sel_t sel =
		int_branch   ? pcs_pkg::PCS_SEL_INT   :
		op_return    ? pcs_pkg::PCS_SEL_RET   :
		op_call      ? pcs_pkg::PCS_SEL_CALL  :
		op_jump      ? pcs_pkg::PCS_SEL_JUMP  :
		low_wr       ? pcs_pkg::PCS_SEL_WRITE :
		fetch_strobe ? pcs_pkg::PCS_SEL_INC   :
		               pcs_pkg::PCS_SEL_HOLD;

	// Eleven bits from the opcode, page bits above them from the latch
	wire pcs_pkg::pcs_addr_t branch_target = {latch[`PCS_LATCH_PAGE], op_target};
	// Low-byte write: upper bits only ever come from the latch
	wire pcs_pkg::pcs_addr_t write_target  = {latch[`PCS_LATCH_HIGH], pwdata[`PCS_WDATA_LOW]};
	wire pcs_pkg::pcs_addr_t inc_target    = 13'(fetch_addr + 1'b1);

	// fetch_addr already points past the branching instruction
	assign stk.push      = (sel == pcs_pkg::PCS_SEL_CALL) | (sel == pcs_pkg::PCS_SEL_INT);
	assign stk.pop       = (sel == pcs_pkg::PCS_SEL_RET);
	assign stk.push_addr = fetch_addr;

	always_comb begin
		case (sel)
			pcs_pkg::PCS_SEL_INT:   next_fetch_addr = `PCS_INT_VECTOR;
			pcs_pkg::PCS_SEL_RET:   next_fetch_addr = stk.top_addr;
			pcs_pkg::PCS_SEL_CALL:  next_fetch_addr = branch_target;
			pcs_pkg::PCS_SEL_JUMP:  next_fetch_addr = branch_target;
			pcs_pkg::PCS_SEL_WRITE: next_fetch_addr = write_target;
			pcs_pkg::PCS_SEL_INC:   next_fetch_addr = inc_target;
			default:                next_fetch_addr = fetch_addr;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fetch_addr <= `PCS_PC_RESET;
		end else begin
			fetch_addr <= next_fetch_addr;
		end
	end

	// Only a software write moves the latch, never a push or pop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latch <= `PCS_LATCH_RESET;
		end else if (latch_wr) begin
			latch <= pwdata[`PCS_WDATA_LATCH];
		end
	end

	// Captured in the setup cycle so prdata is a flop in the access cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata <= `PCS_RDATA_RESET;
		end else if (apb_setup && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// Checks

	property p_reset_zero;
		@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> fetch_addr == `PCS_PC_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("Fetch address not zero after reset");

	property p_increment;
		@(posedge clk_sys) disable iff (rst)
		(fetch_strobe && !int_branch && !op_return && !op_call && !op_jump && !low_wr)
			|=> fetch_addr == 13'($past(fetch_addr) + 1'b1);
	endproperty
	a_increment: assert property (p_increment) else $error("Fetch address did not step by one");

	property p_jump;
		@(posedge clk_sys) disable iff (rst)
		(op_jump && !int_branch && !op_return && !op_call)
			|=> fetch_addr == {$past(latch[`PCS_LATCH_PAGE]), $past(op_target)};
	endproperty
	a_jump: assert property (p_jump) else $error("Jump target not formed from page bits and opcode");

	property p_call_push;
		@(posedge clk_sys) disable iff (rst)
		(op_call && !int_branch && !op_return)
			|=> stk.top_addr == $past(fetch_addr)
			&& fetch_addr == {$past(latch[`PCS_LATCH_PAGE]), $past(op_target)};
	endproperty
	a_call_push: assert property (p_call_push) else $error("Call did not push return address and branch");

	property p_int_push;
		@(posedge clk_sys) disable iff (rst)
		int_branch |=> fetch_addr == `PCS_INT_VECTOR && stk.top_addr == $past(fetch_addr);
	endproperty
	a_int_push: assert property (p_int_push) else $error("Interrupt did not push and vector");

	// One quiet cycle between, as the decoder pulses come
	sequence s_call_then_return;
		stk.push ##1 (!stk.push && !stk.pop) ##1 stk.pop;
	endsequence

	property p_return_restores;
		@(posedge clk_sys) disable iff (rst)
		s_call_then_return |=> fetch_addr == $past(fetch_addr, 3);
	endproperty
	a_return_restores: assert property (p_return_restores) else $error("Return did not restore full address");

	property p_pop_loads;
		@(posedge clk_sys) disable iff (rst)
		(op_return && !int_branch) |=> fetch_addr == $past(stk.top_addr);
	endproperty
	a_pop_loads: assert property (p_pop_loads) else $error("Return did not load stack top");

	property p_latch_kept;
		@(posedge clk_sys) disable iff (rst)
		((stk.push || stk.pop) && !latch_wr) |=> $stable(latch);
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("Latch changed on push or pop");

	property p_low_write;
		@(posedge clk_sys) disable iff (rst)
		(low_wr && sel == pcs_pkg::PCS_SEL_WRITE)
			|=> fetch_addr == {$past(latch), $past(pwdata[`PCS_WDATA_LOW])};
	endproperty
	a_low_write: assert property (p_low_write) else $error("Low-byte write did not load latch bits");

	property p_high_from_latch;
		@(posedge clk_sys) disable iff (rst)
		(sel == pcs_pkg::PCS_SEL_HOLD) |=> $stable(fetch_addr[`PCS_PC_HIGH]);
	endproperty
	a_high_from_latch: assert property (p_high_from_latch) else $error("Upper bits moved without cause");

	property p_read_low;
		@(posedge clk_sys) disable iff (rst)
		(apb_setup && !pwrite && hit_low)
			|=> prdata == {`PCS_PAD_LOW_BYTE, $past(fetch_addr[`PCS_PC_LOW])} && pready;
	endproperty
	a_read_low: assert property (p_read_low) else $error("Low-byte read returned wrong data");

	property p_unmapped;
		@(posedge clk_sys) disable iff (rst)
		(apb_access && !addr_ok) |-> pslverr && pready;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped access not flagged");

	c_call_return: cover property (@(posedge clk_sys) disable iff (rst) s_call_then_return);
	c_int_branch:  cover property (@(posedge clk_sys) disable iff (rst) int_branch ##[1:20] op_return);
	c_low_write:   cover property (@(posedge clk_sys) disable iff (rst) latch_wr ##[1:5] low_wr);
	c_jump_page:   cover property (@(posedge clk_sys) disable iff (rst) op_jump && latch[`PCS_LATCH_PAGE] != 2'h0);

endmodule

// ===== rtl/pcs_pkg.sv
package pcs_pkg;

	typedef logic [12:0] pcs_addr_t;
	typedef logic [10:0] pcs_target_t;
	typedef logic [4:0]  pcs_latch_t;

	// Source of the next fetch address, in rising priority
	typedef enum logic [2:0] {
		PCS_SEL_HOLD,
		PCS_SEL_INC,
		PCS_SEL_WRITE,
		PCS_SEL_JUMP,
		PCS_SEL_CALL,
		PCS_SEL_RET,
		PCS_SEL_INT
	} pcs_sel_t;

endpackage

// ===== rtl/pcs_regs.svh
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// APB byte addresses
`define PCS_ADDR_LOW_BYTE   12'h000
`define PCS_ADDR_LATCH      12'h004

// Reset values
`define PCS_PC_RESET        13'h0000
`define PCS_LATCH_RESET     5'h00
`define PCS_RDATA_RESET     32'h0000_0000

// Fetch address that an interrupt branch goes to
`define PCS_INT_VECTOR      13'h0004

// Field layout of the upper-address latch and the fetch address
`define PCS_LATCH_HIGH      4:0
`define PCS_LATCH_PAGE      4:3
`define PCS_PC_LOW          7:0
`define PCS_PC_HIGH         12:8
`define PCS_WDATA_LOW       7:0
`define PCS_WDATA_LATCH     4:0

// Zero padding above narrow read data
`define PCS_PAD_LOW_BYTE    24'h00_0000
`define PCS_PAD_LATCH       27'h000_0000

// Stack depth
`define PCS_STACK_DEPTH     8

`endif

// ===== rtl/pcs_stack.sv
`timescale 1ns/1ps
`include "pcs_regs.svh"

// Circular return-address store; DEPTH must be a power of two so the
// pointer wraps by itself and a push past DEPTH overwrites the oldest entry.
module pcs_stack #(
	parameter int DEPTH = `PCS_STACK_DEPTH
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	pcs_stk_if.store  stk
);
	localparam int PW = $clog2(DEPTH);

	pcs_pkg::pcs_addr_t mem [DEPTH];
	logic [PW-1:0]      ptr;
	wire  [PW-1:0]      ptr_up   = PW'(ptr + 1'b1);
	wire  [PW-1:0]      ptr_down = PW'(ptr - 1'b1);

	// Pointer lives only here, no software path to it
	assign stk.top_addr = mem[ptr_down];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= `PCS_PC_RESET;
			end
		end else if (stk.push) begin
			mem[ptr] <= stk.push_addr;
			ptr      <= ptr_up;
		end else if (stk.pop) begin
			ptr <= ptr_down;
		end
	end

	// Calls arrive with gaps, so count the run of pushes instead of repeating
	logic [PW:0]   push_run;
	logic [PW-1:0] run_base;
	wire           push_run_full = &push_run;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			push_run <= '0;
			run_base <= '0;
		end else if (stk.push) begin
			if (!push_run_full) begin
				push_run <= (PW+1)'(push_run + 1'b1);
			end
		end else if (stk.pop) begin
			push_run <= '0;
			run_base <= ptr_down;
		end
	end

	property p_wrap;
		@(posedge clk_sys) disable iff (rst)
		(push_run == (PW+1)'(DEPTH)) |-> ptr == run_base;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Stack pointer did not wrap after eight pushes");

	property p_push_top;
		@(posedge clk_sys) disable iff (rst)
		stk.push |=> stk.top_addr == $past(stk.push_addr);
	endproperty
	a_push_top: assert property (p_push_top) else $error("Pushed address not on top of stack");

	c_wrap_ninth: cover property (@(posedge clk_sys) disable iff (rst) stk.push && push_run == (PW+1)'(DEPTH));
endmodule

// ===== rtl/pcs_stk_if.sv
`timescale 1ns/1ps

interface pcs_stk_if;
	logic              push;
	logic              pop;
	pcs_pkg::pcs_addr_t push_addr;
	pcs_pkg::pcs_addr_t top_addr;

	modport ctrl (
		output push,
		output pop,
		output push_addr,
		input  top_addr
	);

	modport store (
		input  push,
		input  pop,
		input  push_addr,
		output top_addr
	);
endinterface

// ===== testbench/pcs_dec_model.sv
`timescale 1ns/1ps

// Stands in for the decoder; target is left inverted between ops so a stale field never looks valid
module pcs_dec_model (
	input  wire logic            clk_sys,
	output logic                 fetch_strobe,
	output logic                 op_jump,
	output logic                 op_call,
	output logic                 op_return,
	output logic                 int_branch,
	output pcs_pkg::pcs_target_t op_target
);
	initial begin
		{fetch_strobe, op_jump, op_call, op_return, int_branch} = 5'h00;
		op_target = 11'h000;
	end

	// Kind: 0 fetch, 1 jump, 2 call, 3 return, 4 interrupt; one pulse per call
	task automatic pulse(input int k, input pcs_pkg::pcs_target_t t);
		@(posedge clk_sys);
		fetch_strobe <= (k == 0);
		op_jump <= (k == 1);
		op_call <= (k == 2);
		op_return <= (k == 3);
		int_branch <= (k == 4);
		op_target <= t;
		@(posedge clk_sys);
		{fetch_strobe, op_jump, op_call, op_return, int_branch} <= 5'h00;
		op_target <= ~t;
	endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	logic                 clk_sys, rst, psel, penable, pwrite, pready, pslverr, e;
	logic                 fetch_strobe, op_jump, op_call, op_return, int_branch;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata, r;
	pcs_pkg::pcs_target_t op_target;
	pcs_pkg::pcs_addr_t   fetch_addr, pc;
	pcs_pkg::pcs_addr_t   stk [8];
	pcs_pkg::pcs_latch_t  lat;
	int                   num_errors, num_checks, sp;

	pcs_core i_pcs_core (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fetch_strobe, .op_jump, .op_call, .op_return, .int_branch, .op_target, .fetch_addr);
	pcs_dec_model i_pcs_dec_model (.clk_sys, .fetch_strobe, .op_jump, .op_call, .op_return,
		.int_branch, .op_target);

	task automatic final_report();
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] a, input logic [31:0] x);
		num_checks++;
		if (a !== x) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, a, x);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			num_errors++;
			final_report();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && a == 12'h000)
			pc = {lat, d[7:0]};
		if (w && a == 12'h004)
			lat = d[4:0];
		#1;
	endtask

	// Expected stack kept here with its own wrapping pointer
	task automatic op(input int k, input pcs_pkg::pcs_target_t t);
		if (k == 2 || k == 4) begin
			stk[sp] = pc;
			sp = (sp + 1) % 8;
		end
		if (k == 3)
			sp = (sp + 7) % 8;
		case (k)
			0: pc = pc + 13'h0001;
			1, 2: pc = {lat[4:3], t};
			3: pc = stk[sp];
			default: pc = 13'h0004;
		endcase
		i_pcs_dec_model.pulse(k, t);
		#1;
		chk(32'(fetch_addr), 32'(pc));
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	initial begin
		#2000000;
		num_errors++;
		final_report();
	end

	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 12'h000, 32'h0000_0000};
		{num_errors, num_checks, sp, pc, lat} = '0;
		stk = '{default: 13'h0000};
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk(32'(fetch_addr), 32'h0000_0000);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		repeat (3) op(0, 11'h000);
		apb(1'b1, 12'h004, 32'hffff_ff1f);
		apb(1'b1, 12'h000, 32'hffff_ff5a);
		chk(32'(fetch_addr), 32'h0000_1f5a);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(r, 32'h0000_005a);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk({r[30:0], e}, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0008);
		op(1, 11'h123);
		for (int i = 0; i < 9; i++) op(2, 11'h7f0 - 11'(i));
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(r, 32'h0000_0008);
		// Page bits changed so a pop leaning on the latch would show
		apb(1'b1, 12'h004, 32'h0000_0010);
		for (int i = 0; i < 9; i++) op(3, 11'h000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(r, 32'h0000_0010);
		op(4, 11'h000);
		op(0, 11'h000);
		op(3, 11'h000);
		op(2, 11'h2aa);
		op(3, 11'h000);
		// Mid-run reset with a nonzero address and latch
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk(32'(fetch_addr), 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		final_report();
	end
endmodule
